// >>> hdl/fsc_defs.svh
// register offsets, field positions and codes for the flash security sequencer
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH
`define FSC_OFS_LOCK_CFG 8'h00
`define FSC_OFS_RSV0 8'h04
`define FSC_OFS_FLASH_CFG 8'h08
`define FSC_OFS_ECC_IRQ_CFG 8'h0C
`define FSC_OFS_FLASH_STAT 8'h10
`define FSC_OFS_ECC_STAT 8'h14
`define FSC_OFS_PF_PROT 8'h18
`define FSC_OFS_EE_PROT 8'h1C
`define FSC_OFS_PARAM_HI 8'h20
`define FSC_OFS_PARAM_LO 8'h24
`define FSC_OFS_RSV1 8'h28
`define FSC_OFS_RSV4 8'h34
`define FSC_OFS_NV_OPT 8'h38
`define FSC_OFS_PARAM_IDX 8'h3C
`define FSC_OFS_IRQ_STAT 8'h40
`define FSC_OFS_IRQ_MASK 8'h44
`define FSC_STAT_DONE 7
`define FSC_STAT_ACCESS_ERROR_FLAG 5
`define FSC_STAT_BUSY 3
`define FSC_STAT_RES1 1
`define FSC_STAT_RES0 0
`define FSC_IRQ_DONE 0
`define FSC_IRQ_ACCESS_ERROR_FLAG 1
`define FSC_IRQ_FAIL 2
`define FSC_FLASH_CFG_WMASK 8'h93
`define FSC_LOCK_RESET 8'hFF
`define FSC_LOCK_FAULT 8'hFF
`define FSC_KEY_ENABLED 2'h2
`define FSC_SEC_UNSECURED 2'h2
`define FSC_SEC_BYTE_ADDR 18'h3FF0F
`define FSC_CMD_ERASE_VERIFY 8'h03
`define FSC_CMD_READ_ONCE 8'h04
`define FSC_IDX_EVS_LAUNCH 3'h2
`define FSC_IDX_RO_LAUNCH 3'h1
`define FSC_IDX_LAST 3'h5
`define FSC_RO_PHRASE_MAX 16'h0007
`define FSC_ERASED_PHRASE 64'hFFFF_FFFF_FFFF_FFFF
`endif

// >>> hdl/fsc_pkg.sv
// types shared by the flash security sequencer
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_BOOT_REQ = 3'b000,
    FSC_BOOT_WAIT = 3'b001,
    FSC_IDLE = 3'b010,
    FSC_RD_REQ = 3'b011,
    FSC_RD_WAIT = 3'b100
  } fsc_state_e;
  typedef struct packed {
    logic valid;
    logic info;
    logic [17:0] addr;
  } fsc_flash_req_s;
  typedef struct packed {
    logic ack;
    logic dbl_fault;
    logic sgl_fault;
    logic [63:0] data;
  } fsc_flash_rsp_s;
endpackage : fsc_pkg

// >>> hdl/fsc_top.sv
// flash security register and erase-verify / read-once command sequencer
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_top
  import fsc_pkg::*;
#(
  parameter logic [17:0] PF_LO = 18'h38000,
  parameter logic [17:0] PF_HI = 18'h3FFFF,
  parameter logic [17:0] INFO_RO_BASE = 18'h00000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fsc_flash_req_s flash_req,
  input wire fsc_flash_rsp_s flash_rsp,
  input wire logic cmd_mode_ok,
  input wire logic backdoor_unlock,
  output logic secured,
  output logic backdoor_enabled,
  output logic irq
);

  if (PF_LO > PF_HI || PF_LO[2:0] != 3'h0 || INFO_RO_BASE[2:0] != 3'h0) begin : g_bad_param
    $error("fsc_top: flash range must be ordered and phrase aligned");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state
  fsc_state_e state_q;
  fsc_flash_req_s freq_q;
  logic [7:0] lock_q;
  logic [7:0] flash_cfg_q;
  logic [2:0] idx_q;
  logic [15:0] slot_q [0:5];
  logic done_q;
  logic access_error_flag_q;
  logic res1_q;
  logic res0_q;
  logic ro_q;
  logic [15:0] cnt_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic secured_q;
  logic key_en_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode and launch checks
  logic apb_wr;
  logic apb_rd;
  logic launch;
  logic [7:0] cmd_code;
  logic [17:0] gaddr;
  logic [19:0] end_addr;
  logic evs_err;
  logic ro_err;
  logic cmd_err;
  logic rd_ack;
  logic rd_last;
  logic rd_bad;
  logic rd_fatal;
  logic rd_finish;
  logic [31:0] rd_val;
  logic rd_hit;

  assign apb_wr = psel & penable & pwrite & pready_q;
  assign apb_rd = psel & penable & ~pready_q;
  assign cmd_code = slot_q[0][15:8];
  assign gaddr = {slot_q[0][1:0], slot_q[1]};
  assign end_addr = {2'b00, gaddr} + {1'b0, slot_q[2], 3'b000};
  // valid launch needs a set done flag and no stale access error
  assign launch = apb_wr & (paddr == `FSC_OFS_FLASH_STAT) & pwdata[`FSC_STAT_DONE]
    & done_q & ~access_error_flag_q & (state_q == FSC_IDLE);
  assign evs_err = (idx_q != `FSC_IDX_EVS_LAUNCH)
    | ~cmd_mode_ok
    | (gaddr < PF_LO) | (gaddr > PF_HI) | (slot_q[2] == 16'h0000)
    | (end_addr > ({2'b00, PF_HI} + 20'h00001))
    | (gaddr[2:0] != 3'h0);
  assign ro_err = (idx_q != `FSC_IDX_RO_LAUNCH) | ~cmd_mode_ok
    | (slot_q[1] > `FSC_RO_PHRASE_MAX);
  always_comb begin
    unique case (cmd_code)
      `FSC_CMD_ERASE_VERIFY: cmd_err = evs_err;
      `FSC_CMD_READ_ONCE: cmd_err = ro_err;
      default: cmd_err = 1'b1;
    endcase
  end

  assign rd_ack = (state_q == FSC_RD_WAIT) & flash_rsp.ack;
  assign rd_last = ro_q | (cnt_q == 16'h0001);
  assign rd_finish = rd_ack & rd_last;
  assign rd_fatal = flash_rsp.dbl_fault | (~ro_q & (flash_rsp.data != `FSC_ERASED_PHRASE));
  assign rd_bad = rd_fatal | flash_rsp.sgl_fault;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and flash read port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= FSC_BOOT_REQ;
      freq_q <= '0;
      cnt_q <= 16'h0000;
      ro_q <= 1'b0;
    end else begin
      unique case (state_q)
        FSC_BOOT_REQ: begin
          freq_q <= '{valid: 1'b1, info: 1'b0, addr: `FSC_SEC_BYTE_ADDR & 18'h3FFF8};
          state_q <= FSC_BOOT_WAIT;
        end
        FSC_BOOT_WAIT: begin
          if (flash_rsp.ack) begin
            freq_q.valid <= 1'b0;
            state_q <= FSC_IDLE;
          end
        end
        FSC_IDLE: begin
          if (launch && !cmd_err) begin
            ro_q <= (cmd_code == `FSC_CMD_READ_ONCE);
            cnt_q <= slot_q[2];
            state_q <= FSC_RD_REQ;
          end
        end
        FSC_RD_REQ: begin
          freq_q.valid <= 1'b1;
          freq_q.info <= ro_q;
          freq_q.addr <= ro_q ? (INFO_RO_BASE + {slot_q[1][14:0], 3'h0}) : gaddr;
          state_q <= FSC_RD_WAIT;
        end
        FSC_RD_WAIT: begin
          if (flash_rsp.ack) begin
            freq_q.valid <= 1'b0;
            cnt_q <= cnt_q - 16'h0001;
            if (!rd_last) begin
              freq_q.valid <= 1'b1;
              freq_q.addr <= freq_q.addr + 18'h00008;
            end else begin
              state_q <= FSC_IDLE;
            end
          end
        end
        default: state_q <= FSC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lock configuration, read only to software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_q <= `FSC_LOCK_RESET;
    end else if (state_q == FSC_BOOT_WAIT && flash_rsp.ack) begin
      lock_q <= flash_rsp.dbl_fault ? `FSC_LOCK_FAULT : flash_rsp.data[7:0];
    end else if (backdoor_unlock && state_q != FSC_BOOT_WAIT
                 && lock_q[7:6] == `FSC_KEY_ENABLED) begin
      lock_q[1:0] <= `FSC_SEC_UNSECURED;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      secured_q <= 1'b1;
      key_en_q <= 1'b0;
    end else begin
      secured_q <= (lock_q[1:0] != `FSC_SEC_UNSECURED);
      key_en_q <= (lock_q[7:6] == `FSC_KEY_ENABLED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      access_error_flag_q <= 1'b0;
      res1_q <= 1'b0;
      res0_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == `FSC_OFS_FLASH_STAT && pwdata[`FSC_STAT_ACCESS_ERROR_FLAG]) begin
        access_error_flag_q <= 1'b0;
      end
      if (launch && cmd_err) begin
        access_error_flag_q <= 1'b1;
      end
      if (launch && !cmd_err) begin
        done_q <= 1'b0;
        res1_q <= 1'b0;
        res0_q <= 1'b0;
      end
      if (rd_ack && rd_bad) begin
        res1_q <= 1'b1;
      end
      if (rd_ack && rd_fatal) begin
        res0_q <= 1'b1;
      end
      if (rd_finish || (state_q == FSC_BOOT_WAIT && flash_rsp.ack)) begin
        done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // parameter window, index and configuration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idx_q <= 3'h0;
      flash_cfg_q <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == `FSC_OFS_PARAM_IDX) begin
        idx_q <= pwdata[2:0];
      end
      if (paddr == `FSC_OFS_FLASH_CFG) begin
        flash_cfg_q <= pwdata[7:0] & `FSC_FLASH_CFG_WMASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        slot_q[i] <= 16'h0000;
      end
    end else if (rd_ack && ro_q) begin
      for (int i = 0; i < 4; i++) begin
        slot_q[i + 2] <= flash_rsp.data[63 - 16 * i -: 16];
      end
    end else if (apb_wr && done_q && idx_q <= `FSC_IDX_LAST) begin
      if (paddr == `FSC_OFS_PARAM_HI) begin
        slot_q[idx_q][15:8] <= pwdata[7:0];
      end
      if (paddr == `FSC_OFS_PARAM_LO) begin
        slot_q[idx_q][7:0] <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == `FSC_OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
      if (apb_wr && paddr == `FSC_OFS_IRQ_STAT) begin
        irq_stat_q <= irq_stat_q & ~pwdata[2:0];
      end
      if (rd_finish || (launch && cmd_err)) begin
        irq_stat_q[`FSC_IRQ_DONE] <= 1'b1;
      end
      if (launch && cmd_err) begin
        irq_stat_q[`FSC_IRQ_ACCESS_ERROR_FLAG] <= 1'b1;
      end
      if (rd_ack && rd_bad) begin
        irq_stat_q[`FSC_IRQ_FAIL] <= 1'b1;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `FSC_OFS_LOCK_CFG: rd_val[7:0] = lock_q;
      `FSC_OFS_FLASH_CFG: rd_val[7:0] = flash_cfg_q;
      `FSC_OFS_FLASH_STAT: begin
        rd_val[`FSC_STAT_DONE] = done_q;
        rd_val[`FSC_STAT_ACCESS_ERROR_FLAG] = access_error_flag_q;
        rd_val[`FSC_STAT_BUSY] = (state_q == FSC_RD_REQ) | (state_q == FSC_RD_WAIT);
        rd_val[`FSC_STAT_RES1] = res1_q;
        rd_val[`FSC_STAT_RES0] = res0_q;
      end
      `FSC_OFS_PARAM_HI: rd_val[7:0] = (idx_q <= `FSC_IDX_LAST) ? slot_q[idx_q][15:8] : 8'h00;
      `FSC_OFS_PARAM_LO: rd_val[7:0] = (idx_q <= `FSC_IDX_LAST) ? slot_q[idx_q][7:0] : 8'h00;
      `FSC_OFS_PARAM_IDX: rd_val[2:0] = idx_q;
      `FSC_OFS_IRQ_STAT: rd_val[2:0] = irq_stat_q;
      `FSC_OFS_IRQ_MASK: rd_val[2:0] = irq_mask_q;
      `FSC_OFS_RSV0, `FSC_OFS_ECC_IRQ_CFG, `FSC_OFS_ECC_STAT, `FSC_OFS_PF_PROT,
      `FSC_OFS_EE_PROT, `FSC_OFS_NV_OPT: rd_val = 32'h0000_0000;
      default: rd_hit = (paddr >= `FSC_OFS_RSV1) && (paddr <= `FSC_OFS_RSV4)
        && (paddr[1:0] == 2'b00);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer, one wait state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_rd;
      pslverr_q <= apb_rd & ~rd_hit;
      if (apb_rd) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_req = freq_q;
  assign secured = secured_q;
  assign backdoor_enabled = key_en_q;
  assign irq = irq_q;

endmodule : fsc_top

// >>> tb/fsc_props.sv
// port assertions for the flash security sequencer
`timescale 1ns/1ps
module fsc_props
  import fsc_pkg::*;
#(
  parameter logic [17:0] PF_LO = 18'h38000,
  parameter logic [17:0] PF_HI = 18'h3FFFF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire fsc_flash_req_s flash_req,
  input wire fsc_flash_rsp_s flash_rsp,
  input wire logic cmd_mode_ok,
  input wire logic backdoor_unlock,
  input wire logic secured,
  input wire logic backdoor_enabled
);
  logic boot_q;
  logic rd_lock;
  logic launch;
  assign rd_lock = pready && !pwrite && paddr == 8'h00;
  assign launch = psel && penable && pready && pwrite && paddr == 8'h10 && pwdata[7];
  always_ff @(posedge clk) begin
    if (!reset_n) boot_q <= 1'b1;
    else if (flash_rsp.ack) boot_q <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_boot;
    $rose(reset_n) |-> ##[0:2] flash_req.valid && flash_req.addr == 18'h3FF08;
  endproperty
  a_boot: assert property (p_boot) else $error("boot fetch");
  property p_fault;
    flash_rsp.ack && flash_rsp.dbl_fault && boot_q |-> ##2 (secured && !backdoor_enabled) [*2];
  endproperty
  a_fault: assert property (p_fault) else $error("fault lock");
  property p_key;
    rd_lock |-> backdoor_enabled == (prdata[7:6] == 2'b10);
  endproperty
  a_key: assert property (p_key) else $error("key map");
  property p_sec;
    rd_lock |-> secured == (prdata[1:0] != 2'b10);
  endproperty
  a_sec: assert property (p_sec) else $error("sec map");
  property p_unlock;
    backdoor_unlock && backdoor_enabled |-> ##[1:3] !secured;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock");
  property p_range;
    flash_req.valid && !flash_req.info && !boot_q |-> flash_req.addr[2:0] == 3'h0
      && flash_req.addr >= PF_LO && flash_req.addr <= PF_HI;
  endproperty
  a_range: assert property (p_range) else $error("phrase range");
  property p_result;
    pready && !pwrite && paddr == 8'h10 |-> prdata[1] || !prdata[0];
  endproperty
  a_result: assert property (p_result) else $error("result bits");
  property p_refuse;
    launch && !cmd_mode_ok && !flash_req.valid |=> !flash_req.valid [*4];
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused launch");
  c_launch: cover property (launch && cmd_mode_ok);
  c_fault: cover property (flash_rsp.ack && flash_rsp.dbl_fault);
  c_unlock: cover property (backdoor_unlock && backdoor_enabled);
endmodule : fsc_props

// >>> tb/fsc_flash_model.sv
// flash array stand-in answering phrase reads
`timescale 1ns/1ps
module fsc_flash_model
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire fsc_flash_req_s req,
  output fsc_flash_rsp_s rsp,
  input wire logic [7:0] sec_byte,
  input wire logic dbl,
  input wire logic [17:0] bad_addr,
  input wire logic [2:0] lat
);
  logic [2:0] cnt;
  logic [15:0] a;
  assign a = req.addr[15:0];
  initial begin
    rsp = '0;
    cnt = '0;
  end
  ////////////////////////////////////////
  always @(posedge clk) begin
    rsp.ack <= 1'b0;
    rsp.dbl_fault <= 1'b0;
    rsp.sgl_fault <= 1'b0;
    rsp.data <= ~rsp.data;
    if (req.valid && !rsp.ack) begin
      cnt <= cnt + 3'h1;
      if (cnt >= lat) begin
        cnt <= '0;
        rsp.ack <= 1'b1;
        rsp.dbl_fault <= dbl && req.addr == 18'h3FF08;
        rsp.sgl_fault <= req.info && req.addr[5:3] == 3'h7;
        if (req.info)
          rsp.data <= {a ^ 16'hA000, a ^ 16'hB000, a ^ 16'hC000, a ^ 16'hD000};
        else if (req.addr == 18'h3FF08)
          rsp.data <= {56'hFF_FFFF_FFFF_FFFF, sec_byte};
        else
          rsp.data <= req.addr == bad_addr ? 64'h0 : 64'hFFFF_FFFF_FFFF_FFFF;
      end
    end
  end
endmodule : fsc_flash_model

// >>> tb/tb_top.sv
// self-checking bench for the flash security sequencer
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, cmd_mode_ok, backdoor_unlock, dbl, err;
  logic pready, pslverr, secured, backdoor_enabled, irq;
  logic [7:0] paddr, sec_byte, e;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] bad_addr;
  logic [2:0] lat;
  logic [15:0] ph;
  logic [15:0] q[$];
  logic [7:0] sbt[4] = '{8'hBD, 8'h7E, 8'h3C, 8'hBE};
  fsc_flash_req_s flash_req;
  fsc_flash_rsp_s flash_rsp;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h1143;
  fsc_top i_fsc_top (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flash_req, .flash_rsp, .cmd_mode_ok, .backdoor_unlock, .secured,
    .backdoor_enabled, .irq);
  fsc_flash_model i_fsc_flash_model (.clk, .req(flash_req), .rsp(flash_rsp), .sec_byte,
    .dbl, .bad_addr, .lat);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        error_cnt++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rc(string n, logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, rd);
  endtask : rc
  task automatic slot(logic [2:0] k, logic [15:0] v);
    apb(1'b1, 8'h3C, {29'h0, k});
    apb(1'b1, 8'h20, {24'h0, v[15:8]});
    apb(1'b1, 8'h24, {24'h0, v[7:0]});
  endtask : slot
  task automatic wdone;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      n++;
      if (n > 200) begin
        error_cnt++;
        tally_and_finish();
      end
    end while (rd[7] !== 1'b1);
  endtask : wdone
  task automatic go;
    lat <= 3'($random(seed));
    apb(1'b1, 8'h10, 32'h80);
    wdone();
  endtask : go
  initial begin
    {psel, penable, pwrite, backdoor_unlock} <= 4'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    cmd_mode_ok <= 1'b1;
    bad_addr <= 18'h0;
    lat <= 3'h0;
    for (int p = 0; p < 4; p++) begin
      sec_byte <= sbt[p];
      dbl <= p == 3;
      reset_n <= 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      wdone();
      e = p == 3 ? 8'hFF : sbt[p];
      rc("lock", 8'h00, e);
      apb(1'b1, 8'h00, 32'h0);
      rc("lock", 8'h00, e);
      chk("key", e[7:6] == 2'b10, backdoor_enabled);
      backdoor_unlock <= 1'b1;
      @(posedge clk);
      backdoor_unlock <= 1'b0;
      repeat (3) @(posedge clk);
      if (e[7:6] == 2'b10) e[1:0] = 2'b10;
      rc("lock", 8'h00, e);
      chk("sec", e[1:0] != 2'b10, secured);
      $display("end boot %0d", p);
    end
    for (int b = 0; b < 2; b++) begin
      bad_addr <= b ? 18'h38010 : 18'h0;
      slot(0, 16'h0303);
      slot(1, 16'h8000);
      slot(2, 16'h0004);
      go();
      chk("stat", b ? 32'h83 : 32'h80, rd & 32'hA3);
    end
    $display("end verify");
    for (int t = 0; t < 4; t++) begin
      slot(0, 16'h0303);
      slot(1, t == 2 ? 16'h8004 : t == 3 ? 16'hFFF8 : 16'h8000);
      slot(2, 16'h0002);
      if (t == 0) apb(1'b1, 8'h3C, 32'h1);
      cmd_mode_ok <= t != 1;
      go();
      chk("access_error_flag", 32'hA0, rd & 32'hA0);
      apb(1'b1, 8'h10, 32'h20);
      cmd_mode_ok <= 1'b1;
    end
    rc("irqst", 8'h40, 32'h7);
    apb(1'b1, 8'h44, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, irq);
    apb(1'b1, 8'h44, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, irq);
    apb(1'b1, 8'h40, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, irq);
    $display("end errors");
    for (int r = 0; r < 2; r++) begin
      ph = r ? 16'h0007 : 16'($random(seed)) & 16'h7;
      slot(0, 16'h0400);
      slot(1, ph);
      go();
      chk("stat", ph == 16'h0007 ? 32'h82 : 32'h80, rd & 32'hA3);
      for (int k = 0; k < 4; k++)
        q.push_back(16'(ph * 8) ^ 16'(16'hA000 + k * 16'h1000));
      for (int k = 2; k < 6; k++) begin
        apb(1'b1, 8'h3C, k);
        apb(1'b0, 8'h20, 32'h0);
        e = rd[7:0];
        apb(1'b0, 8'h24, 32'h0);
        chk("word", q.pop_front(), {e, rd[7:0]});
      end
    end
    for (int u = 0; u < 3; u++) begin
      slot(0, u == 2 ? 16'h0500 : 16'h0400);
      slot(1, u == 0 ? 16'h0008 : 16'h0000);
      cmd_mode_ok <= u != 1;
      go();
      chk("access_error_flag", 32'hA0, rd & 32'hA0);
      apb(1'b1, 8'h10, 32'h20);
      cmd_mode_ok <= 1'b1;
    end
    apb(1'b0, 8'h80, 32'h0);
    chk("slverr", 32'h1, err);
    $display("end read once");
    tally_and_finish();
  end
endmodule : tb_top
bind fsc_top fsc_props #(.PF_LO(PF_LO), .PF_HI(PF_HI)) i_fsc_props (.clk, .reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .flash_req, .flash_rsp, .cmd_mode_ok,
  .backdoor_unlock, .secured, .backdoor_enabled);
